// file: logic/bts_defs.svh
// Function
// R01: There are exactly two event counters, and each has one compare value that every state shares.
// R02: A counter action with no counter chosen works on counter one.
// R03: Only the matchers of the current state are evaluated, so a later state's matcher waits for a transfer into it.
// R04: A trigger action fires the trigger on the bus cycle whose match caused it.
// R05: A state with no transfer action is held, and its conditions are evaluated, until the next arm.
// R06: An else clause acts on the next qualified bus cycle on which no other clause of the state holds.
// R07: All actions of a taken else clause happen together on that same bus cycle; the code drops the transfer when the clause also triggers.
// R08: Matchers ORed in one clause are evaluated in parallel, and any one of them fires the clause.
// R09: Two clauses, each with its own matcher, act exactly like one clause with both matchers ORed.
// R10: A count action adds one to its counter for each qualified cycle on which it fires.
// R11: After the trigger, both counter values and the triggering state stay readable.
// R12: The state changes only through a transfer action.
// R13: A compare condition holds while its counter equals that counter's compare value.
// R14: A matcher fires when every cared-for address, data and control bit equals the sampled bus.
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH
`define BTS_ADDR_W 16
`define BTS_DATA_W 8
`define BTS_CTRL_W 8
`define BTS_CTR_W 16
`define BTS_SIDX_W 2
`define BTS_CLAUSES 3
`define BTS_ELSE_CLAUSE 2
`define BTS_MATCHERS 2
`define BTS_CTR_RST 16'h0000
`define BTS_CTR_INC 16'h0001
`define BTS_FIRST_STATE 2'h0
`define BTS_SEL_ONE 1'b0
`endif

// file: logic/bts_pkg.sv
`include "bts_defs.svh"
package bts_pkg;
	typedef enum logic [1:0] {
		BTS_IDLE,
		BTS_RUN,
		BTS_DONE
	} bts_mode_t;

	typedef struct packed {
		logic [`BTS_ADDR_W-1:0] addr;
		logic [`BTS_DATA_W-1:0] data;
		logic [`BTS_CTRL_W-1:0] ctrl;
	} bts_word_t;

	// Condition: OR of chosen terms; actions fire together, except that a trigger cancels the transfer
	typedef struct packed {
		logic use_a;
		logic use_b;
		logic use_cmp;
		logic cmp_sel;
		logic state_transfer_action_en;
		logic [`BTS_SIDX_W-1:0] state_transfer_action_target;
		logic cnt_en;
		logic cnt_sel;
		logic trig_en;
	} bts_clause_t;

	typedef struct packed {
		bts_mode_t mode;
		logic [`BTS_SIDX_W-1:0] state_idx;
		logic [`BTS_CTR_W-1:0] ctr_one;
		logic [`BTS_CTR_W-1:0] ctr_two;
		logic [`BTS_SIDX_W-1:0] trig_state;
		logic trig_pulse;
		bts_word_t bus_meta;
		bts_word_t bus_sync;
		logic valid_meta;
		logic valid_sync;
		logic valid_prev;
	} bts_state_t;
endpackage

// file: logic/bts_word_matcher.sv
`timescale 1ns/10ps
module bts_word_matcher
	import bts_pkg::*;
(
	input wire bts_word_t value_in,
	input wire bts_word_t care_in,
	input wire bts_word_t sample_in,
	output logic match_out
);
	// Cleared care bits are don't-care
	assign match_out = ((value_in ^ sample_in) & care_in) == '0; // R14
endmodule

// file: logic/bts_sequencer.sv
`timescale 1ns/10ps
`include "bts_defs.svh"
module bts_sequencer
	import bts_pkg::*;
#(
	parameter int NUM_STATES = 4
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [`BTS_ADDR_W-1:0] bus_addr_in,
	input wire logic [`BTS_DATA_W-1:0] bus_data_in,
	input wire logic [`BTS_CTRL_W-1:0] bus_ctrl_in,
	input wire logic bus_cycle_in,
	input wire logic arm_in,
	input wire bts_word_t match_val_in [NUM_STATES][`BTS_MATCHERS],
	input wire bts_word_t match_care_in [NUM_STATES][`BTS_MATCHERS],
	input wire bts_clause_t clause_cfg_in [NUM_STATES][`BTS_CLAUSES],
	input wire logic [`BTS_CTR_W-1:0] cmp_one_in,
	input wire logic [`BTS_CTR_W-1:0] cmp_two_in,
	output logic [`BTS_SIDX_W-1:0] state_out,
	output logic [`BTS_CTR_W-1:0] event_counter_one_out,
	output logic [`BTS_CTR_W-1:0] event_counter_two_out,
	output logic [`BTS_SIDX_W-1:0] trigger_state_report_out,
	output logic trigger_out,
	output logic running_out,
	output logic triggered_out
);
	bts_state_t st_reg;
	bts_state_t st_next;
	logic match_w [NUM_STATES][`BTS_MATCHERS];
	logic cyc;
	logic live;
	logic [1:0] hit;
	logic [2:0] act;
	logic else_present;
	logic inc_one;
	logic inc_two;
	logic trig;
	logic state_transfer_action_take;
	logic [`BTS_SIDX_W-1:0] state_transfer_action_tgt;
	bts_clause_t cl;
	bts_clause_t else_cl;

	genvar gs, gm;
	generate
		for (gs = 0; gs < NUM_STATES; gs++) begin : g_state
			for (gm = 0; gm < `BTS_MATCHERS; gm++) begin : g_match
				bts_word_matcher u_match (
					.value_in(match_val_in[gs][gm]),
					.care_in(match_care_in[gs][gm]),
					.sample_in(st_reg.bus_sync),
					.match_out(match_w[gs][gm])
				);
			end
		end
	endgenerate

	// Qualified cycle: rising edge of the synchronised strobe
	assign cyc = st_reg.valid_sync & ~st_reg.valid_prev;
	assign live = cyc && (st_reg.mode == BTS_RUN);

	always_comb begin
		st_next = st_reg;
		st_next.bus_meta = {bus_addr_in, bus_data_in, bus_ctrl_in};
		st_next.bus_sync = st_reg.bus_meta;
		st_next.valid_meta = bus_cycle_in;
		st_next.valid_sync = st_reg.valid_meta;
		st_next.valid_prev = st_reg.valid_sync;
		st_next.trig_pulse = 1'b0;
		hit = 2'b00;
		act = 3'b000;
		inc_one = 1'b0;
		inc_two = 1'b0;
		trig = 1'b0;
		state_transfer_action_take = 1'b0;
		state_transfer_action_tgt = st_reg.state_idx;
		cl = clause_cfg_in[st_reg.state_idx][`BTS_ELSE_CLAUSE];
		else_present = cl.state_transfer_action_en | cl.cnt_en | cl.trig_en;
		// Only the current state's matchers take part
		for (int c = 0; c < 2; c++) begin // R03
			cl = clause_cfg_in[st_reg.state_idx][c];
			hit[c] = live && ((cl.use_a && match_w[st_reg.state_idx][0]) // R08
				|| (cl.use_b && match_w[st_reg.state_idx][1]) // R09
				|| (cl.use_cmp && (cl.cmp_sel ? (st_reg.ctr_two == cmp_two_in) // R13
				: (st_reg.ctr_one == cmp_one_in)))); // R01
		end
		act[1:0] = hit;
		act[2] = live && else_present && (hit == 2'b00); // R06
		// Lowest clause wins when two transfers disagree
		for (int c = `BTS_CLAUSES - 1; c >= 0; c--) begin
			cl = clause_cfg_in[st_reg.state_idx][c];
			if (act[c]) begin // R07
				if (cl.cnt_en && (cl.cnt_sel == `BTS_SEL_ONE)) begin // R02
					inc_one = 1'b1;
				end
				if (cl.cnt_en && (cl.cnt_sel != `BTS_SEL_ONE)) begin
					inc_two = 1'b1;
				end
				if (cl.trig_en) begin
					trig = 1'b1;
				end
				if (cl.state_transfer_action_en) begin // R12
					state_transfer_action_take = 1'b1;
					state_transfer_action_tgt = cl.state_transfer_action_target;
				end
			end
		end
		if (inc_one) begin
			st_next.ctr_one = st_reg.ctr_one + `BTS_CTR_INC; // R10
		end
		if (inc_two) begin
			st_next.ctr_two = st_reg.ctr_two + `BTS_CTR_INC; // R10
		end
		case (st_reg.mode)
			BTS_RUN: begin
				if (trig) begin
					// Freeze state so the report names where it fired
					st_next.mode = BTS_DONE;
					st_next.trig_state = st_reg.state_idx; // R11
					st_next.trig_pulse = 1'b1; // R04
				end else if (state_transfer_action_take) begin
					st_next.state_idx = state_transfer_action_tgt; // R12
				end
			end
			BTS_IDLE, BTS_DONE: begin
				st_next.mode = st_reg.mode;
			end
			default: begin
				st_next.mode = BTS_IDLE;
			end
		endcase
		// Stays in a state without a transfer until rearmed
		if (arm_in) begin // R05
			st_next.mode = BTS_RUN;
			st_next.state_idx = `BTS_FIRST_STATE;
			st_next.ctr_one = `BTS_CTR_RST;
			st_next.ctr_two = `BTS_CTR_RST;
			st_next.trig_pulse = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_reg <= '0;
			st_reg.mode <= BTS_IDLE;
			st_reg.state_idx <= `BTS_FIRST_STATE;
			st_reg.ctr_one <= `BTS_CTR_RST;
			st_reg.ctr_two <= `BTS_CTR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign state_out = st_reg.state_idx;
	assign event_counter_one_out = st_reg.ctr_one;
	assign event_counter_two_out = st_reg.ctr_two;
	assign trigger_state_report_out = st_reg.trig_state;
	assign trigger_out = st_reg.trig_pulse;
	assign running_out = st_reg.mode == BTS_RUN;
	assign triggered_out = st_reg.mode == BTS_DONE;
	assign else_cl = clause_cfg_in[st_reg.state_idx][`BTS_ELSE_CLAUSE];

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	chk_trig_on_match: assert property (live && trig && !arm_in |=> trigger_out) // R04
		else $error("trigger not raised after triggering match");

	chk_trig_report: assert property (trigger_out // R11
		|-> trigger_state_report_out == state_out && triggered_out)
		else $error("trigger state report wrong");

	chk_trig_single: assert property (trigger_out |=> !trigger_out) // R04
		else $error("trigger pulse longer than one cycle");

	chk_hold_state: assert property (!state_transfer_action_take && !arm_in |=> $stable(state_out)) // R05
		else $error("state left without transfer");

	chk_state_transfer_action_target: assert property (state_transfer_action_take && !trig && !arm_in // R12
		|=> state_out == $past(state_transfer_action_tgt))
		else $error("transfer went to wrong state");

	chk_count_one_step: assert property (inc_one && !arm_in // R10
		|=> event_counter_one_out == $past(event_counter_one_out) + `BTS_CTR_INC)
		else $error("counter one did not step by one");

	chk_count_two_step: assert property (inc_two && !arm_in // R10
		|=> event_counter_two_out == $past(event_counter_two_out) + `BTS_CTR_INC)
		else $error("counter two did not step by one");

	chk_count_quiet: assert property (!live && !arm_in // R10
		|=> $stable(event_counter_one_out) && $stable(event_counter_two_out))
		else $error("counter moved without qualified cycle");

	// Else judged by its effect, not by the decode that feeds it
	chk_else_branch: assert property (live && hit == 2'b00 && else_cl.state_transfer_action_en // R06
		&& !else_cl.trig_en && !arm_in |=> state_out == $past(else_cl.state_transfer_action_target))
		else $error("else clause did not transfer");

	chk_else_count: assert property (live && hit == 2'b00 && else_cl.cnt_en // R07
		&& else_cl.cnt_sel == `BTS_SEL_ONE && !arm_in
		|=> event_counter_one_out == $past(event_counter_one_out) + `BTS_CTR_INC)
		else $error("else clause did not count");

	chk_match_only_live: assert property (!live && !arm_in // R03
		|=> !trigger_out && $stable(state_out))
		else $error("state acted outside a qualified running cycle");

	chk_done_frozen: assert property ((triggered_out && !arm_in) [*2] // R11
		|-> $stable(state_out) && $stable(trigger_state_report_out))
		else $error("report changed after trigger");

	chk_arm_restart: assert property (arm_in |=> running_out && !trigger_out // R05
		&& state_out == `BTS_FIRST_STATE && event_counter_one_out == `BTS_CTR_RST
		&& event_counter_two_out == `BTS_CTR_RST)
		else $error("arm did not restart the sequence");

	cov_trigger: cover property (trigger_out);
	cov_else_taken: cover property (act[2] && state_transfer_action_take);
	cov_state_transfer_action: cover property (state_transfer_action_take && !trig);
	cov_both_hit: cover property (hit == 2'b11);
	cov_rearm: cover property (arm_in && triggered_out);
endmodule

// file: test/bts_bus_model.sv
`timescale 1ns/10ps
module bts_bus_model
	import bts_pkg::*;
(
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic slow_in,
	input wire bts_word_t word_in,
	output bts_word_t pins_out,
	output logic strobe_out,
	output logic done_out
);
	bts_word_t held;
	logic [3:0] cnt = 4'h0;
	initial begin
		pins_out = '0;
		strobe_out = 1'b0;
		done_out = 1'b0;
	end
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (cnt == 4'h0) begin
			if (start_in) begin
				pins_out <= word_in;
				held <= word_in;
				strobe_out <= 1'b1;
				cnt <= 4'h1;
			end
		end else begin
			cnt <= cnt + 4'h1;
			// Pins stay put one cycle past the strobe fall
			if (cnt == 4'h3)
				strobe_out <= 1'b0;
			// Released lines must not keep the old word
			if (cnt == 4'h4)
				pins_out <= ~held;
			if (cnt == (slow_in ? 4'hb : 4'h7)) begin
				done_out <= 1'b1;
				cnt <= 4'h0;
			end
		end
	end
endmodule

// file: test/bus_trigger_sequencer_tb.sv
`timescale 1ns/10ps
module bus_trigger_sequencer_tb
	import bts_pkg::*;
;
	typedef struct {
		bts_word_t w;
		logic [1:0] st;
		logic [15:0] c1;
		logic [15:0] c2;
		int tr;
	} bts_row_t;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic arm_in = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	bts_word_t word = '0;
	bts_word_t pins;
	logic strobe, done;
	bts_word_t mval [4][2];
	bts_word_t mcare [4][2];
	bts_clause_t ccfg [4][3];
	logic [15:0] cmp_one = 16'h0002;
	logic [15:0] cmp_two = 16'h0001;
	logic [1:0] st, rep;
	logic [15:0] c1, c2;
	logic trig, run, trd;
	int fail_count = 0;
	int checks_done = 0;
	int trig_seen = 0;
	bts_row_t rows [9] = '{
		'{'{16'h0000, 8'h34, 8'h00}, 2'h0, 16'h0001, 16'h0000, 0},
		'{'{16'h0000, 8'hff, 8'h00}, 2'h0, 16'h0001, 16'h0000, 0},
		'{'{16'h0000, 8'h34, 8'h00}, 2'h0, 16'h0002, 16'h0000, 0},
		'{'{16'h0000, 8'h00, 8'h00}, 2'h1, 16'h0002, 16'h0000, 0},
		'{'{16'h0000, 8'hf6, 8'h00}, 2'h1, 16'h0002, 16'h0001, 0},
		'{'{16'h0000, 8'h00, 8'h00}, 2'h2, 16'h0002, 16'h0001, 0},
		'{'{16'h0000, 8'h00, 8'h00}, 2'h2, 16'h0002, 16'h0001, 0},
		'{'{16'h0011, 8'h00, 8'h00}, 2'h2, 16'h0002, 16'h0001, 1},
		'{'{16'h0000, 8'h34, 8'h00}, 2'h2, 16'h0002, 16'h0001, 1}};
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in)
		if (trig === 1'b1)
			trig_seen++;
	bts_bus_model i_bts_bus_model(.clk_in(clk_in), .start_in(start), .slow_in(slow),
		.word_in(word), .pins_out(pins), .strobe_out(strobe), .done_out(done));
	bts_sequencer i_bts_sequencer(.clk_in(clk_in), .reset_in(reset_in),
		.bus_addr_in(pins.addr), .bus_data_in(pins.data), .bus_ctrl_in(pins.ctrl),
		.bus_cycle_in(strobe), .arm_in(arm_in), .match_val_in(mval), .match_care_in(mcare),
		.clause_cfg_in(ccfg), .cmp_one_in(cmp_one), .cmp_two_in(cmp_two), .state_out(st),
		.event_counter_one_out(c1), .event_counter_two_out(c2),
		.trigger_state_report_out(rep), .trigger_out(trig), .running_out(run),
		.triggered_out(trd));
	task close_out;
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask
	task apply(input bts_row_t r);
		int n;
		n = 0;
		word = r.w;
		start = 1'b1;
		@(posedge clk_in);
		#1 start = 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge clk_in);
			#1 n++;
		end
		if (n >= 50) begin
			fail_count++;
			close_out();
		end
		check("state", 16'(st), 16'(r.st));
		check("counter one", c1, r.c1);
		check("counter two", c2, r.c2);
		check("triggers", 16'(trig_seen), 16'(r.tr));
	endtask
	task arm;
		arm_in = 1'b1;
		@(posedge clk_in);
		#1 arm_in = 1'b0;
		trig_seen = 0;
		check("running", 16'(run), 16'h0001);
	endtask
	initial begin
		foreach (ccfg[s, k])
			ccfg[s][k] = '0;
		foreach (mval[s, k])
			mval[s][k] = '0;
		foreach (mcare[s, k])
			mcare[s][k] = '0;
		mval[0][0].data = 8'h34;
		mval[1][0].data = 8'hf6;
		mval[2][0].data = 8'hff;
		mval[2][1].addr = 16'h0011;
		for (int s = 0; s < 3; s++)
			mcare[s][0].data = 8'hff;
		mcare[2][1].addr = 16'hffff;
		ccfg[0][0] = '{use_a: 1'b1, cnt_en: 1'b1, default: 1'b0};
		ccfg[0][1] = '{use_cmp: 1'b1, state_transfer_action_en: 1'b1, state_transfer_action_target: 2'h1, default: 1'b0};
		ccfg[1][0] = '{use_a: 1'b1, cnt_en: 1'b1, cnt_sel: 1'b1, default: 1'b0};
		ccfg[1][1] = '{use_cmp: 1'b1, cmp_sel: 1'b1, state_transfer_action_en: 1'b1, state_transfer_action_target: 2'h2,
			default: 1'b0};
		ccfg[2][0] = '{use_a: 1'b1, use_b: 1'b1, trig_en: 1'b1, default: 1'b0};
		repeat (6) @(posedge clk_in);
		#1 reset_in = 1'b0;
		check("reset flags", {13'h0, run, trd, trig}, 16'h0000);
		check("reset counters", c1 | c2 | 16'(st) | 16'(rep), 16'h0000);
		arm();
		foreach (rows[i])
			apply(rows[i]);
		check("report", 16'(rep), 16'h0002);
		check("done", 16'(trd), 16'h0001);
		check("running after trigger", 16'(run), 16'h0000);
		// Else program, slow bus to vary the spacing
		ccfg[0][1] = '0;
		ccfg[0][0] = '{use_a: 1'b1, state_transfer_action_en: 1'b1, state_transfer_action_target: 2'h3, default: 1'b0};
		mval[0][0] = '{16'h783d, 8'h00, 8'h00};
		mcare[0][0] = '{16'hffff, 8'h00, 8'h00};
		mval[3][0] = '{16'h9107, 8'h00, 8'h00};
		mcare[3][0] = '{16'hffff, 8'h00, 8'h00};
		ccfg[3][0] = '{use_a: 1'b1, trig_en: 1'b1, default: 1'b0};
		ccfg[3][2] = '{state_transfer_action_en: 1'b1, state_transfer_action_target: 2'h0, cnt_en: 1'b1, default: 1'b0};
		slow = 1'b1;
		arm();
		apply('{'{16'h783d, 8'h00, 8'h00}, 2'h3, 16'h0000, 16'h0000, 0});
		apply('{'{16'h1234, 8'h00, 8'h00}, 2'h0, 16'h0001, 16'h0000, 0});
		apply('{'{16'h783d, 8'h00, 8'h00}, 2'h3, 16'h0001, 16'h0000, 0});
		apply('{'{16'h9107, 8'h00, 8'h00}, 2'h3, 16'h0001, 16'h0000, 1});
		check("report", 16'(rep), 16'h0003);
		// Two clauses, each on its own matcher, must act like one ORed clause
		ccfg[0][0] = '{use_a: 1'b1, trig_en: 1'b1, default: 1'b0};
		ccfg[0][1] = '{use_b: 1'b1, trig_en: 1'b1, default: 1'b0};
		mval[0][1] = '{16'h4455, 8'h00, 8'h00};
		mcare[0][1] = '{16'hffff, 8'h00, 8'h00};
		arm();
		apply('{'{16'h4455, 8'h00, 8'h00}, 2'h0, 16'h0000, 16'h0000, 1});
		check("report", 16'(rep), 16'h0000);
		// Reset after the trigger must clear a finished sequence
		reset_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1 reset_in = 1'b0;
		check("reset again", {13'h0, run, trd, trig} | c1 | c2, 16'h0000);
		close_out();
	end
endmodule
